// [cso_consts.svh]
// Constants for the carry and subtract datapath block
//
// Contract
// (RULE_01) Add-with-carry to memory: byte plus carry, back to the byte.
// (RULE_02) Subtract immediate: working_register minus constant, kept there.
// (RULE_03) Subtract memory source: working_register minus byte, to working.
// (RULE_04) Subtraction adds the two's complement of the subtrahend.
// (RULE_05) Subtract to memory: byte minus working_register, to the byte.
// (RULE_06) Borrow subtract, memory source: working minus byte minus carry.
// (RULE_07) Borrow subtract to memory: byte minus working minus carry.
// (RULE_08) Single borrow subtract: working_register minus carry only.
// (RULE_09) Single borrow subtract on memory: byte minus carry, to the byte.
// (RULE_10) All ops update zero, carry, nibble, range flags; carry is borrow.
`ifndef CSO_CONSTS_SVH
`define CSO_CONSTS_SVH

`define CSO_OFF_CMD 8'h00
`define CSO_OFF_WORK 8'h04
`define CSO_OFF_MEM 8'h08
`define CSO_OFF_IMM 8'h0c
`define CSO_OFF_FLAGS 8'h10

`define CSO_OP_ADDC_M 4'h0
`define CSO_OP_SUB_A_I 4'h1
`define CSO_OP_SUB_A_M 4'h2
`define CSO_OP_SUB_M_A 4'h3
`define CSO_OP_SUBC_A_M 4'h4
`define CSO_OP_SUBC_M_A 4'h5
`define CSO_OP_SUBC_A 4'h6
`define CSO_OP_SUBC_M 4'h7

`define CSO_FLG_Z 0
`define CSO_FLG_C 1
`define CSO_FLG_NB 2
`define CSO_FLG_SR 3

`define CSO_RST_BYTE 8'h00
`define CSO_RST_FLAGS 4'h0
`define CSO_RST_OP 4'h0
`define CSO_RST_WORD 32'h0000_0000
`define CSO_BYTE_ZERO 8'h00
`define CSO_BYTE_ONES 8'hff

`endif

// [cso_pkg.sv]
// Types shared by the carry and subtract datapath block
`include "cso_consts.svh"
package cso_pkg;
   typedef enum logic [3:0] {
      CSO_ADDC_M = `CSO_OP_ADDC_M,
      CSO_SUB_A_I = `CSO_OP_SUB_A_I,
      CSO_SUB_A_M = `CSO_OP_SUB_A_M,
      CSO_SUB_M_A = `CSO_OP_SUB_M_A,
      CSO_SUBC_A_M = `CSO_OP_SUBC_A_M,
      CSO_SUBC_M_A = `CSO_OP_SUBC_M_A,
      CSO_SUBC_A = `CSO_OP_SUBC_A,
      CSO_SUBC_M = `CSO_OP_SUBC_M
   } cso_op_e;
endpackage

// [cso_alu.sv]
// Combinational adder core for the carry and subtract operations
`timescale 1ns/1ps
`include "cso_consts.svh"
module cso_alu (
   input wire logic [3:0] op,
   input wire logic [7:0] work,
   input wire logic [7:0] mem,
   input wire logic [7:0] imm,
   input wire logic carry,
   output logic [7:0] result,
   output logic to_mem,
   output logic [3:0] flags,
   output logic legal
);
   logic [7:0] x;
   logic [7:0] y;
   logic cin;
   logic sub;
   logic [8:0] sum9;
   logic [4:0] lo5;

   always_comb begin
      x = work;
      y = `CSO_BYTE_ZERO;
      cin = 1'b0;
      sub = 1'b1;
      to_mem = 1'b0;
      legal = 1'b1;
      // Borrow in is an inverted carry in, so one adder serves all forms
      unique case (cso_pkg::cso_op_e'(op))
         cso_pkg::CSO_ADDC_M: begin
            x = mem; // RULE_01
            cin = carry;
            sub = 1'b0;
            to_mem = 1'b1;
         end
         cso_pkg::CSO_SUB_A_I: begin
            y = ~imm; // RULE_02
            cin = 1'b1; // RULE_04
         end
         cso_pkg::CSO_SUB_A_M: begin
            y = ~mem; // RULE_03
            cin = 1'b1; // RULE_04
         end
         cso_pkg::CSO_SUB_M_A: begin
            x = mem; // RULE_05
            y = ~work;
            cin = 1'b1; // RULE_04
            to_mem = 1'b1;
         end
         cso_pkg::CSO_SUBC_A_M: begin
            y = ~mem; // RULE_06
            cin = ~carry;
         end
         cso_pkg::CSO_SUBC_M_A: begin
            x = mem; // RULE_07
            y = ~work;
            cin = ~carry;
            to_mem = 1'b1;
         end
         cso_pkg::CSO_SUBC_A: begin
            y = `CSO_BYTE_ONES; // RULE_08
            cin = ~carry;
         end
         cso_pkg::CSO_SUBC_M: begin
            x = mem; // RULE_09
            y = `CSO_BYTE_ONES;
            cin = ~carry;
            to_mem = 1'b1;
         end
         default: begin
            legal = 1'b0;
         end
      endcase
   end

   assign sum9 = {1'b0, x} + {1'b0, y} + {8'h00, cin}; // RULE_04
   assign lo5 = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
   assign result = sum9[7:0];

   always_comb begin
      flags = `CSO_RST_FLAGS;
      flags[`CSO_FLG_Z] = (sum9[7:0] == `CSO_BYTE_ZERO); // RULE_10
      flags[`CSO_FLG_C] = sum9[8] ^ sub; // RULE_10
      flags[`CSO_FLG_NB] = lo5[4] ^ sub; // RULE_10
      flags[`CSO_FLG_SR] = (x[7] == y[7]) && (sum9[7] != x[7]); // RULE_10
   end
endmodule // cso_alu

// [cso_top.sv]
// APB register front end and state of the carry and subtract datapath
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`include "cso_consts.svh"
module cso_top #(
   parameter int ADDR_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic zero_flag,
   output logic carry_flag,
   output logic nibble_borrow_flag,
   output logic signed_range_error_flag
);
   logic [7:0] work_r;
   logic [7:0] work_nxt;
   logic [7:0] mem_r;
   logic [7:0] mem_nxt;
   logic [7:0] imm_r;
   logic [7:0] imm_nxt;
   logic [3:0] flags_r;
   logic [3:0] flags_nxt;
   logic [3:0] op_r;
   logic [3:0] op_nxt;
   logic [31:0] prdata_r;
   logic [31:0] prdata_nxt;
   logic pready_r;
   logic pready_nxt;
   logic pslverr_r;
   logic pslverr_nxt;
   logic sel_cmd;
   logic sel_work;
   logic sel_mem;
   logic sel_imm;
   logic sel_flags;
   logic mapped;
   logic first_access;
   logic done;
   logic wr_take;
   logic exec_w;
   logic [7:0] alu_result;
   logic alu_to_mem;
   logic [3:0] alu_flags;
   logic alu_legal;

   assign sel_cmd = (paddr == ADDR_W'(`CSO_OFF_CMD));
   assign sel_work = (paddr == ADDR_W'(`CSO_OFF_WORK));
   assign sel_mem = (paddr == ADDR_W'(`CSO_OFF_MEM));
   assign sel_imm = (paddr == ADDR_W'(`CSO_OFF_IMM));
   assign sel_flags = (paddr == ADDR_W'(`CSO_OFF_FLAGS));
   assign mapped = sel_cmd | sel_work | sel_mem | sel_imm | sel_flags;
   // One wait state lets read data and error leave straight from flops
   assign first_access = psel & penable & ~pready_r;
   assign done = psel & penable & pready_r;
   // Lane 0 carries every register; other lanes alone change nothing
   assign wr_take = done & pwrite & ~pslverr_r & pstrb[0];
   assign exec_w = wr_take & sel_cmd;

   cso_alu u_alu (
      .op(pwdata[3:0]),
      .work(work_r),
      .mem(mem_r),
      .imm(imm_r),
      .carry(flags_r[`CSO_FLG_C]),
      .result(alu_result),
      .to_mem(alu_to_mem),
      .flags(alu_flags),
      .legal(alu_legal)
   );

   always_comb begin
      pready_nxt = 1'b0;
      prdata_nxt = prdata_r;
      pslverr_nxt = 1'b0;
      if (first_access) begin
         pready_nxt = 1'b1;
         prdata_nxt = `CSO_RST_WORD;
         // Unknown address or op code is refused, nothing changes
         pslverr_nxt = ~mapped | (pwrite & sel_cmd & ~alu_legal);
         if (!pwrite) begin
            if (sel_cmd) begin
               prdata_nxt = 32'(op_r);
            end else if (sel_work) begin
               prdata_nxt = 32'(work_r);
            end else if (sel_mem) begin
               prdata_nxt = 32'(mem_r);
            end else if (sel_imm) begin
               prdata_nxt = 32'(imm_r);
            end else if (sel_flags) begin
               prdata_nxt = 32'(flags_r);
            end
         end
      end
   end

   always_comb begin
      work_nxt = work_r;
      mem_nxt = mem_r;
      imm_nxt = imm_r;
      flags_nxt = flags_r;
      op_nxt = op_r;
      if (exec_w) begin
         op_nxt = pwdata[3:0];
         flags_nxt = alu_flags; // RULE_10
         if (alu_to_mem) begin
            mem_nxt = alu_result; // RULE_01
         end else begin
            work_nxt = alu_result; // RULE_02
         end
      end else if (wr_take) begin
         if (sel_work) begin
            work_nxt = pwdata[7:0];
         end else if (sel_mem) begin
            mem_nxt = pwdata[7:0];
         end else if (sel_imm) begin
            imm_nxt = pwdata[7:0];
         end else if (sel_flags) begin
            flags_nxt = pwdata[3:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         work_r <= `CSO_RST_BYTE;
         mem_r <= `CSO_RST_BYTE;
         imm_r <= `CSO_RST_BYTE;
         flags_r <= `CSO_RST_FLAGS;
         op_r <= `CSO_RST_OP;
         prdata_r <= `CSO_RST_WORD;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         work_r <= work_nxt;
         mem_r <= mem_nxt;
         imm_r <= imm_nxt;
         flags_r <= flags_nxt;
         op_r <= op_nxt;
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign zero_flag = flags_r[`CSO_FLG_Z];
   assign carry_flag = flags_r[`CSO_FLG_C];
   assign nibble_borrow_flag = flags_r[`CSO_FLG_NB];
   assign signed_range_error_flag = flags_r[`CSO_FLG_SR];

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_access_start;
      psel && penable && !pready_r;
   endsequence

   sequence s_run(logic [3:0] code);
      exec_w && (pwdata[3:0] == code);
   endsequence

   a_apb_one_wait: assert property (
      s_access_start |=> pready_r ##1 !pready_r)
      else $error("pready not one wait state");

   a_addc_mem: assert property ( // RULE_01
      s_run(`CSO_OP_ADDC_M) |=> (mem_r == 8'($past(mem_r)
         + $past(flags_r[`CSO_FLG_C]))) && $stable(work_r))
      else $error("add carry to memory wrong");

   a_sub_imm: assert property ( // RULE_02
      s_run(`CSO_OP_SUB_A_I) |=>
         work_r == 8'($past(work_r) - $past(imm_r)))
      else $error("subtract immediate wrong");

   a_sub_borrow: assert property ( // RULE_04
      s_run(`CSO_OP_SUB_A_I) |=>
         flags_r[`CSO_FLG_C] == ($past(work_r) < $past(imm_r)))
      else $error("subtract borrow wrong");

   a_sub_mem_src: assert property ( // RULE_03
      s_run(`CSO_OP_SUB_A_M) |=>
         (work_r == 8'($past(work_r) - $past(mem_r))) && $stable(mem_r))
      else $error("subtract memory source wrong");

   a_sub_mem_dst: assert property ( // RULE_05
      s_run(`CSO_OP_SUB_M_A) |=>
         (mem_r == 8'($past(mem_r) - $past(work_r))) && $stable(work_r))
      else $error("subtract memory destination wrong");

   a_sbb_src: assert property ( // RULE_06
      s_run(`CSO_OP_SUBC_A_M) |=> work_r == 8'($past(work_r)
         - $past(mem_r) - $past(flags_r[`CSO_FLG_C])))
      else $error("borrow subtract source wrong");

   a_sbb_dst: assert property ( // RULE_07
      s_run(`CSO_OP_SUBC_M_A) |=> mem_r == 8'($past(mem_r)
         - $past(work_r) - $past(flags_r[`CSO_FLG_C])))
      else $error("borrow subtract destination wrong");

   a_sbb_work: assert property ( // RULE_08
      s_run(`CSO_OP_SUBC_A) |=> work_r == 8'($past(work_r)
         - $past(flags_r[`CSO_FLG_C])))
      else $error("borrow subtract working wrong");

   a_sbb_mem: assert property ( // RULE_09
      s_run(`CSO_OP_SUBC_M) |=> (mem_r == 8'($past(mem_r)
         - $past(flags_r[`CSO_FLG_C]))) && $stable(work_r))
      else $error("borrow subtract memory wrong");

   a_zero_flag: assert property ( // RULE_10
      exec_w |=> flags_r[`CSO_FLG_Z] == ($past(alu_to_mem)
         ? (mem_r == `CSO_BYTE_ZERO) : (work_r == `CSO_BYTE_ZERO)))
      else $error("zero flag wrong");

   a_err_no_write: assert property (
      done && pslverr_r |=> $stable(work_r) && $stable(mem_r)
         && $stable(flags_r))
      else $error("refused access changed state");
endmodule // cso_top

// [test_carry_subtract_alu_ops.sv]
// Self-checking bench for the carry and subtract datapath block
`timescale 1ns/1ps
`include "cso_consts.svh"
module test_carry_subtract_alu_ops;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr, w, m, i;
   logic [31:0] pwdata, prdata, rd, wv, mv, fv;
   logic [3:0] pstrb, op, fl;
   logic zf, cf, af, of;
   logic [12:0] e;
   logic [7:0] cv [4] = '{8'h00, 8'h7f, 8'h80, 8'hff};
   int errors, num_checks;

   cso_top #(.ADDR_W(8)) i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .zero_flag(zf), .carry_flag(cf), .nibble_borrow_flag(af),
      .signed_range_error_flag(of)
   );

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen,
                  exp);
      end
   endtask

   task automatic conclude;
      if (errors == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Answer is taken at the rising edge where pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) errors++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d}, 4'hf);
   endtask

   task automatic rdr(input logic [7:0] a);
      apb(1'b0, a, 32'h0, 4'h0);
   endtask

   // Returns {to_mem, range, nibble, carry, zero, result}
   function automatic logic [12:0] model(input logic [3:0] o,
      input logic [7:0] wk, mb, im, input logic c);
      logic [7:0] x, y, r;
      logic [8:0] s;
      logic [4:0] h;
      logic cin, sub, ov, tm;
      sub = (o != 4'h0);
      tm = (o == 4'h0 || o == 4'h3 || o == 4'h5 || o == 4'h7);
      x = tm ? mb : wk;
      case (o)
         4'h1: y = im;
         4'h2, 4'h4: y = mb;
         4'h3, 4'h5: y = wk;
         default: y = 8'h00;
      endcase
      cin = (o == 4'h0) ? c : ((o >= 4'h4) ? ~c : 1'b1);
      // Subtract as x plus inverted y; carry out inverted gives borrow
      if (sub) y = ~y;
      s = {1'b0, x} + {1'b0, y} + {8'h00, cin};
      h = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
      r = s[7:0];
      ov = (x[7] == y[7]) && (r[7] != x[7]);
      return {tm, ov, h[4] ^ sub, s[8] ^ sub, r == 8'h00, r};
   endfunction

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'h0;
      errors = 0;
      num_checks = 0;
      void'($urandom(39407));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      for (int k = 0; k < 5; k++) begin
         rdr(8'(4 * k));
         check(rd, 32'h0);
      end
      rdr(8'h14);
      check({31'h0, err}, 32'h1);
      for (int n = 0; n < 240; n++) begin
         op = 4'(n % 8);
         w = 8'($urandom);
         m = 8'($urandom);
         i = 8'($urandom);
         fl = 4'($urandom);
         // Corner sweep of sign and nibble boundaries first
         if (n < 64) begin
            w = cv[(n / 8) % 4];
            m = cv[(n / 2) % 4];
            i = cv[n % 4];
            fl[1] = n[5];
         end
         wr(`CSO_OFF_WORK, w);
         wr(`CSO_OFF_MEM, m);
         wr(`CSO_OFF_IMM, i);
         wr(`CSO_OFF_FLAGS, {4'h0, fl});
         if (n % 5 == 0) apb(1'b1, `CSO_OFF_WORK, {24'h0, ~w}, 4'he);
         if (n % 16 == 7) begin
            wr(8'h14, i);
            check({31'h0, err}, 32'h1);
         end
         wr(`CSO_OFF_CMD, {4'h0, op});
         check({31'h0, err}, 32'h0);
         if (n % 16 == 15) begin
            wr(`CSO_OFF_CMD, {4'h0, 4'h8 | op});
            check({31'h0, err}, 32'h1);
         end
         e = model(op, w, m, i, fl[1]);
         rdr(`CSO_OFF_WORK);
         wv = rd;
         rdr(`CSO_OFF_MEM);
         mv = rd;
         rdr(`CSO_OFF_FLAGS);
         fv = rd;
         case (op)
            4'h0: check(mv, {24'h0, e[7:0]});
            4'h1: check(wv, {24'h0, e[7:0]});
            4'h2: check(wv, {24'h0, e[7:0]});
            4'h3: check(mv, {24'h0, e[7:0]});
            4'h4: check(wv, {24'h0, e[7:0]});
            4'h5: check(mv, {24'h0, e[7:0]});
            4'h6: check(wv, {24'h0, e[7:0]});
            default: check(mv, {24'h0, e[7:0]});
         endcase
         check(e[12] ? wv : mv, {24'h0, e[12] ? w : m});
         check({31'h0, fv[1]}, {31'h0, e[9]});
         check(fv, {28'h0, e[11:8]});
         check({28'h0, of, af, cf, zf}, {28'h0, e[11:8]});
      end
      conclude();
   end

   // Run takes about 8000 cycles; generous margin before giving up
   initial begin
      repeat (60000) @(posedge pclk);
      errors++;
      conclude();
   end
endmodule // test_carry_subtract_alu_ops
